// ---- inc/bank1_regs_pkg.sv ----
// Constants and carrier types for the bank-1 special register map
package bank1_regs_pkg;
	// ----------------------------------------
	// Addresses
	// ----------------------------------------
	localparam logic [7:0] A_INDIRECT_PORT = 8'h80;
	localparam logic [7:0] A_T0_CONFIG = 8'h81;
	localparam logic [7:0] A_PC_LOW = 8'h82;
	localparam logic [7:0] A_FLAGS = 8'h83;
	localparam logic [7:0] A_IND_POINTER = 8'h84;
	localparam logic [7:0] A_DIR_A = 8'h85;
	localparam logic [7:0] A_DIR_B = 8'h86;
	localparam logic [7:0] A_DIR_C = 8'h87;
	localparam logic [7:0] A_DIR_D = 8'h88;
	localparam logic [7:0] A_DIR_E = 8'h89;
	localparam logic [7:0] A_PC_LATCH = 8'h8A;
	localparam logic [7:0] A_CORE_IRQ = 8'h8B;
	localparam logic [7:0] A_IRQ_EN1 = 8'h8C;
	localparam logic [7:0] A_IRQ_EN2 = 8'h8D;
	localparam logic [7:0] A_PWR_FLAGS = 8'h8E;
	localparam logic [7:0] A_T2_PERIOD = 8'h92;
	localparam logic [7:0] A_SSP_ADDR = 8'h93;
	localparam logic [7:0] A_SSP_FLAGS = 8'h94;
	localparam logic [7:0] A_TX_CTRL = 8'h98;
	localparam logic [7:0] A_BAUD = 8'h99;
	localparam logic [2:0] BANK1_TAG = 3'h4;
	// ----------------------------------------
	// Writable bit masks
	// ----------------------------------------
	localparam logic [7:0] M_ALL = 8'hFF;
	localparam logic [7:0] M_FLAGS_HI = 8'hE0;
	localparam logic [7:0] M_FLAGS_ALU = 8'h07;
	localparam logic [7:0] M_DIR_A = 8'h3F;
	localparam logic [7:0] M_DIR_E = 8'h37;
	localparam logic [7:0] M_PC_LATCH = 8'h1F;
	localparam logic [7:0] M_CORE_IRQ = 8'hFE;
	localparam logic [7:0] M_IRQ_EN2 = 8'h01;
	localparam logic [7:0] M_PWR = 8'h03;
	localparam logic [7:0] M_SSP_FLAGS = 8'h3F;
	localparam logic [7:0] M_TX_CTRL = 8'hF5;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] R_ONES = 8'hFF;
	localparam logic [7:0] R_ZERO = 8'h00;
	localparam logic [7:0] R_FLAGS = 8'h18;
	localparam logic [7:0] R_DIR_A = 8'h3F;
	localparam logic [7:0] R_DIR_E = 8'h07;
	localparam logic [7:0] R_TX_CTRL = 8'h02;
	// Bit positions
	localparam int B_TO = 4;
	localparam int B_PD = 3;
	localparam int B_IND_BANK = 7;
	localparam int B_IBOV = 5;
	localparam int B_POR = 1;
	localparam int B_BROWNOUT_FLAG = 0;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] t0_config;
		logic [7:0] flags;
		logic [7:0] ind_pointer;
		logic [7:0] dir_a;
		logic [7:0] dir_b;
		logic [7:0] dir_c;
		logic [7:0] dir_d;
		logic [7:0] dir_e;
		logic [7:0] pc_latch;
		logic [7:0] core_irq;
		logic [7:0] irq_en1;
		logic [7:0] irq_en2;
		logic [7:0] pwr_flags;
		logic [7:0] t2_period;
		logic [7:0] ssp_addr;
		logic [7:0] tx_ctrl;
		logic [7:0] baud;
	} ctl_s;
	typedef struct packed {
		logic [7:0] t0_config;
		logic [7:0] flags_hi;
		logic [7:0] dir_a;
		logic [7:0] dir_b;
		logic [7:0] dir_c;
		logic [7:0] dir_d;
		logic [7:0] dir_e;
		logic [7:0] pc_latch;
		logic [7:0] core_irq;
		logic [7:0] irq_en1;
		logic [7:0] irq_en2;
		logic [7:0] pwr_flags;
		logic [7:0] t2_period;
		logic [7:0] ssp_addr;
		logic [7:0] tx_ctrl;
		logic [7:0] baud;
		logic [7:0] pc_low;
		logic [7:0] rdata;
		logic pc_load;
		logic [12:0] pc_value;
	} st_s;
	typedef struct packed {
		logic [7:0] ind_pointer;
		logic [2:0] alu;
		logic irq_pin_flag;
	} keep_s;
endpackage

// ---- logic/bank1_special_register_map.sv ----
// Bank-1 special register file with bank-0 mirrors of the core registers
// ----------------------------------------
// What this block does and what firmware must keep
// RL1: Unmapped addresses read zero, ignore writes
// RL2: Unimplemented bits inside registers read zero
// RL3: Shared core registers mirror in both banks
// RL4: PC high only via 5-bit latch transfer
// RL5: Pin and watchdog resets load other column
// RL6: Unknown bits not forced, unchanged bits kept
// RL7: Power flags reset by cause, else kept
// RL8: Firmware keeps brown-out flag written one
// RL9: Firmware keeps upper bank bits zero
// RL10: Firmware keeps interrupt bit six clear
// RL11: Indirect port accesses memory at pointer
// RL12: Power-on/brown-out loads tabulated defaults
// ----------------------------------------
`timescale 1ns/1ns
module bank1_special_register_map
	import bank1_regs_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	output logic [7:0] rdata,
	input wire logic brownout_reset,
	input wire logic external_reset_pin,
	input wire logic watchdog_reset,
	input wire logic sleep_cmd,
	input wire logic wdt_clear_cmd,
	input wire logic psp_in_full,
	input wire logic psp_out_full,
	input wire logic psp_overflow,
	input wire logic tx_shift_empty,
	input wire logic [7:0] ssp_status,
	output logic [8:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	output logic pc_load,
	output logic [12:0] pc_value,
	output ctl_s ctl
);
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	st_s s;
	st_s next_s;
	keep_s k;
	keep_s next_k;
	logic shared;
	logic hit;
	logic [7:0] key;
	logic indirect;
	logic other_rst;
	// Bank-0 aliases of the core registers
	always_comb begin
		case (addr[6:0])
			A_INDIRECT_PORT[6:0], A_PC_LOW[6:0], A_FLAGS[6:0],
			A_IND_POINTER[6:0], A_PC_LATCH[6:0], A_CORE_IRQ[6:0]: shared = 1'b1; // RL3
			default: shared = 1'b0;
		endcase
	end
	assign hit = (addr[7:5] == BANK1_TAG) || (!addr[7] && shared); // RL3
	assign key = {BANK1_TAG, addr[4:0]};
	assign indirect = hit && (key == A_INDIRECT_PORT);
	assign other_rst = external_reset_pin || watchdog_reset;
	// Pointer at the port itself reads zero; avoids a loop
	assign mem_addr = {s.flags_hi[B_IND_BANK], k.ind_pointer}; // RL11
	assign mem_rd = rd_strobe && indirect && (k.ind_pointer != R_ZERO); // RL11
	assign mem_wr = wr_strobe && indirect && (k.ind_pointer != R_ZERO); // RL11
	assign mem_wdata = wdata;
	function automatic logic [7:0] merge(input logic [7:0] o, d, m);
		merge = (o & ~m) | (d & m);
	endfunction
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_k = k;
		next_s.rdata = R_ZERO;
		next_s.pc_load = 1'b0;
		if (rd_strobe && hit) begin
			case (key)
				A_INDIRECT_PORT: next_s.rdata = mem_rd ? mem_rdata : R_ZERO; // RL11
				A_T0_CONFIG: next_s.rdata = s.t0_config;
				A_PC_LOW: next_s.rdata = s.pc_low;
				A_FLAGS: next_s.rdata = s.flags_hi | {5'h00, k.alu};
				A_IND_POINTER: next_s.rdata = k.ind_pointer;
				A_DIR_A: next_s.rdata = s.dir_a & M_DIR_A; // RL2
				A_DIR_B: next_s.rdata = s.dir_b;
				A_DIR_C: next_s.rdata = s.dir_c;
				A_DIR_D: next_s.rdata = s.dir_d;
				A_DIR_E: next_s.rdata = (s.dir_e & M_DIR_E) |
					{psp_in_full, psp_out_full, 6'h00}; // RL2
				A_PC_LATCH: next_s.rdata = s.pc_latch & M_PC_LATCH; // RL2 RL4
				A_CORE_IRQ: next_s.rdata = s.core_irq | {7'h00, k.irq_pin_flag};
				A_IRQ_EN1: next_s.rdata = s.irq_en1;
				A_IRQ_EN2: next_s.rdata = s.irq_en2 & M_IRQ_EN2; // RL2
				A_PWR_FLAGS: next_s.rdata = s.pwr_flags & M_PWR; // RL2
				A_T2_PERIOD: next_s.rdata = s.t2_period;
				A_SSP_ADDR: next_s.rdata = s.ssp_addr;
				A_SSP_FLAGS: next_s.rdata = ssp_status & M_SSP_FLAGS; // RL2
				A_TX_CTRL: next_s.rdata = (s.tx_ctrl & M_TX_CTRL) |
					{6'h00, tx_shift_empty, 1'b0}; // RL2
				A_BAUD: next_s.rdata = s.baud;
				default: next_s.rdata = R_ZERO; // RL1
			endcase
		end
		if (wr_strobe && hit) begin
			case (key)
				A_T0_CONFIG: next_s.t0_config = wdata;
				A_PC_LOW: begin
					next_s.pc_low = wdata;
					// Upper PC bits come only from the latch
					next_s.pc_load = 1'b1; // RL4
					next_s.pc_value = {s.pc_latch[4:0], wdata}; // RL4
				end
				A_FLAGS: begin
					next_s.flags_hi = merge(s.flags_hi, wdata, M_FLAGS_HI);
					next_k.alu = wdata[2:0];
				end
				A_IND_POINTER: next_k.ind_pointer = wdata;
				A_DIR_A: next_s.dir_a = merge(s.dir_a, wdata, M_DIR_A); // RL2
				A_DIR_B: next_s.dir_b = wdata;
				A_DIR_C: next_s.dir_c = wdata;
				A_DIR_D: next_s.dir_d = wdata;
				A_DIR_E: next_s.dir_e = merge(s.dir_e, wdata, M_DIR_E); // RL2
				A_PC_LATCH: next_s.pc_latch = merge(s.pc_latch, wdata, M_PC_LATCH); // RL4
				A_CORE_IRQ: begin
					next_s.core_irq = merge(s.core_irq, wdata, M_CORE_IRQ);
					next_k.irq_pin_flag = wdata[0];
				end
				A_IRQ_EN1: next_s.irq_en1 = wdata;
				A_IRQ_EN2: next_s.irq_en2 = merge(s.irq_en2, wdata, M_IRQ_EN2); // RL2
				A_PWR_FLAGS: next_s.pwr_flags = merge(s.pwr_flags, wdata, M_PWR);
				A_T2_PERIOD: next_s.t2_period = wdata;
				A_SSP_ADDR: next_s.ssp_addr = wdata;
				A_TX_CTRL: next_s.tx_ctrl = merge(s.tx_ctrl, wdata, M_TX_CTRL);
				A_BAUD: next_s.baud = wdata;
				default: next_s = next_s; // RL1
			endcase
		end
		// Hardware set beats a same-cycle software clear
		if (psp_overflow)
			next_s.dir_e[B_IBOV] = 1'b1;
		if (wdt_clear_cmd) begin
			next_s.flags_hi[B_TO] = 1'b1;
			next_s.flags_hi[B_PD] = 1'b1;
		end else if (sleep_cmd) begin
			next_s.flags_hi[B_TO] = 1'b1;
			next_s.flags_hi[B_PD] = 1'b0;
		end
		if (brownout_reset) begin
			next_s.t0_config = R_ONES; // RL12
			next_s.flags_hi = R_FLAGS; // RL12
			next_s.dir_a = R_DIR_A; // RL12
			next_s.dir_b = R_ONES; // RL12
			next_s.dir_c = R_ONES;
			next_s.dir_d = R_ONES;
			next_s.dir_e = R_DIR_E;
			next_s.pc_latch = R_ZERO;
			next_s.core_irq = R_ZERO;
			next_s.irq_en1 = R_ZERO;
			next_s.irq_en2 = R_ZERO;
			next_s.t2_period = R_ONES; // RL12
			next_s.ssp_addr = R_ZERO;
			next_s.tx_ctrl = R_TX_CTRL & M_TX_CTRL;
			next_s.baud = R_ZERO;
			next_s.pc_low = R_ZERO;
			next_s.pc_load = 1'b0;
			// A reset drops a same-cycle PC write
			next_s.pc_value = s.pc_value;
			next_s.pwr_flags[B_BROWNOUT_FLAG] = 1'b0; // RL7
		end else if (other_rst) begin
			next_s.t0_config = R_ONES; // RL5
			next_s.flags_hi[7:5] = 3'h0; // RL5
			if (watchdog_reset)
				next_s.flags_hi[B_TO] = 1'b0; // RL5
			next_s.dir_a = R_DIR_A; // RL5
			next_s.dir_b = R_ONES;
			next_s.dir_c = R_ONES;
			next_s.dir_d = R_ONES;
			next_s.dir_e = R_DIR_E;
			next_s.pc_latch = R_ZERO;
			next_s.core_irq = R_ZERO;
			next_s.irq_en1 = R_ZERO;
			next_s.irq_en2 = R_ZERO;
			next_s.t2_period = R_ONES;
			next_s.ssp_addr = R_ZERO;
			next_s.tx_ctrl = R_TX_CTRL & M_TX_CTRL;
			next_s.baud = R_ZERO;
			next_s.pc_low = R_ZERO;
			next_s.pc_load = 1'b0;
			next_s.pc_value = s.pc_value;
			next_s.pwr_flags = s.pwr_flags; // RL7
		end
		// Pointer, ALU flags and pin flag untouched by any reset
		if (brownout_reset || other_rst)
			next_k = k; // RL6
	end
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= '{t0_config: R_ONES, flags_hi: R_FLAGS, dir_a: R_DIR_A, // RL12
				dir_b: R_ONES, dir_c: R_ONES, dir_d: R_ONES, dir_e: R_DIR_E,
				pc_latch: R_ZERO, core_irq: R_ZERO, irq_en1: R_ZERO, irq_en2: R_ZERO,
				pwr_flags: R_ZERO, t2_period: R_ONES, ssp_addr: R_ZERO, // RL7
				tx_ctrl: R_TX_CTRL & M_TX_CTRL, baud: R_ZERO, pc_low: R_ZERO,
				rdata: R_ZERO, pc_load: 1'b0, pc_value: 13'h0000};
		end else begin
			s <= next_s;
		end
	end
	// Unknown-at-power-up bits carry no reset at all
	always_ff @(posedge clk) begin
		k <= next_k; // RL6
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata = s.rdata;
	assign pc_load = s.pc_load;
	assign pc_value = s.pc_value;
	assign ctl = '{t0_config: s.t0_config, flags: s.flags_hi | {5'h00, k.alu},
		ind_pointer: k.ind_pointer, dir_a: s.dir_a, dir_b: s.dir_b,
		dir_c: s.dir_c, dir_d: s.dir_d, dir_e: s.dir_e, pc_latch: s.pc_latch,
		core_irq: s.core_irq | {7'h00, k.irq_pin_flag}, irq_en1: s.irq_en1,
		irq_en2: s.irq_en2, pwr_flags: s.pwr_flags, t2_period: s.t2_period,
		ssp_addr: s.ssp_addr, tx_ctrl: s.tx_ctrl, baud: s.baud};
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_unmapped_reads_zero: assert property ( // RL1
		rd_strobe && !hit |=> rdata == R_ZERO)
		else $error("unmapped read not zero");
	a_reserved_bits_zero: assert property ( // RL2
		rd_strobe && hit && key == A_PC_LATCH |=> rdata[7:5] == 3'h0)
		else $error("latch upper bits not zero");
	a_mirror_write_same: assert property ( // RL3
		wr_strobe && addr == A_PC_LATCH[6:0] && !brownout_reset && !other_rst
		|=> ctl.pc_latch == ($past(wdata) & M_PC_LATCH))
		else $error("bank-0 alias write lost");
	a_pc_transfer_latch: assert property ( // RL4
		wr_strobe && hit && key == A_PC_LOW && !brownout_reset && !other_rst
		|=> pc_load && pc_value == {$past(ctl.pc_latch[4:0]), $past(wdata)})
		else $error("pc load wrong");
	a_other_reset_column: assert property ( // RL5
		other_rst && !brownout_reset |=> ctl.t0_config == R_ONES &&
		ctl.pwr_flags == $past(ctl.pwr_flags))
		else $error("pin/watchdog reset column wrong");
	a_pointer_kept_reset: assert property ( // RL6
		brownout_reset || other_rst |=> $stable(ctl.ind_pointer))
		else $error("pointer changed by reset");
	a_brownout_flag_cause: assert property ( // RL7
		brownout_reset |=> !ctl.pwr_flags[B_BROWNOUT_FLAG] &&
		ctl.pwr_flags[B_POR] == $past(ctl.pwr_flags[B_POR]))
		else $error("power flags wrong after brown-out");
	a_indirect_redirect: assert property ( // RL11
		rd_strobe && indirect && ctl.ind_pointer != R_ZERO
		|-> mem_rd ##1 rdata == $past(mem_rdata))
		else $error("indirect read not redirected");
	a_defaults_loaded: assert property ( // RL12
		brownout_reset |=> ctl.dir_b == R_ONES && ctl.t2_period == R_ONES &&
		pc_value == $past(pc_value) && !pc_load)
		else $error("brown-out defaults wrong");
	// Aliases must read as the bank-1 view
	a_alias_flags_read: assert property ( // RL3
		rd_strobe && addr == {1'b0, A_FLAGS[6:0]} |=> rdata == $past(ctl.flags))
		else $error("flags alias read differs");
	a_alias_pointer_read: assert property ( // RL3
		rd_strobe && addr == {1'b0, A_IND_POINTER[6:0]}
		|=> rdata == $past(ctl.ind_pointer))
		else $error("pointer alias read differs");
	a_dir_a_upper: assert property ( // RL2
		rd_strobe && hit && key == A_DIR_A |=> rdata[7:6] == 2'h0)
		else $error("direction A upper bits not zero");
	a_unmapped_write_void: assert property ( // RL1
		wr_strobe && !hit && !psp_overflow && !brownout_reset && !other_rst
		|=> $stable({ctl.t0_config, ctl.dir_a, ctl.dir_b, ctl.dir_c, ctl.dir_d,
		ctl.dir_e, ctl.pc_latch, ctl.t2_period, ctl.ssp_addr, ctl.baud}))
		else $error("unmapped write changed a register");
	a_latch_no_load: assert property ( // RL4
		wr_strobe && hit && key == A_PC_LATCH |=> !pc_load)
		else $error("latch write loaded the pc");
	a_watchdog_timeout: assert property ( // RL5
		watchdog_reset && !brownout_reset |=> !ctl.flags[B_TO])
		else $error("watchdog reset left timeout bit set");
	a_pin_keeps_timeout: assert property ( // RL5
		external_reset_pin && !watchdog_reset && !brownout_reset && !wdt_clear_cmd &&
		!sleep_cmd |=> ctl.flags[B_TO] == $past(ctl.flags[B_TO]))
		else $error("pin reset changed timeout bit");
	a_unknown_bits_kept: assert property ( // RL6
		brownout_reset || other_rst |=> $stable({ctl.flags[2:0], ctl.core_irq[0]}))
		else $error("unreset bits changed by reset");
	c_indirect_read: cover property (rd_strobe && indirect ##1 rdata != R_ZERO);
	c_brownout_reset: cover property (brownout_reset ##1 !ctl.pwr_flags[B_BROWNOUT_FLAG]);
	c_alias_write: cover property (wr_strobe && hit && !addr[7]);
	c_pc_load: cover property (wr_strobe && key == A_PC_LOW && hit ##1 pc_load);
	c_watchdog_reset: cover property (watchdog_reset ##1 !ctl.flags[B_TO]);
endmodule

// ---- dv/bank1_special_register_map_tb.sv ----
// Self-checking bench for the bank-1 special register map
`timescale 1ns/1ns
module bank1_special_register_map_tb;
	import bank1_regs_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr_strobe = 1'b0;
	logic rd_strobe = 1'b0;
	logic [7:0] rdata;
	// brownout, pin, watchdog, sleep, wdt clear
	logic [4:0] ev = 5'h00;
	logic [1:0] psp_full = 2'h0;
	logic psp_ovf = 1'b0;
	logic tx_empty = 1'b1;
	logic [7:0] ssp_status = 8'h00;
	logic [8:0] mem_addr;
	logic mem_rd;
	logic mem_wr;
	logic [7:0] mem_wdata;
	logic pc_load;
	logic [12:0] pc_value;
	ctl_s ctl;
	int n_mismatch = 0;
	int num_checks = 0;
	// ----------------------------------------
	// Expected tables
	// ----------------------------------------
	localparam logic [7:0] RA [0:13] = '{8'h81, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8A,
		8'h8C, 8'h8D, 8'h8E, 8'h92, 8'h93, 8'h98, 8'h99};
	localparam logic [7:0] RV [0:13] = '{8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h00,
		8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h02, 8'h00};
	// Gaps of the bank plus a bank-0 address that is not shared
	localparam logic [7:0] UA [0:10] = '{8'h8F, 8'h90, 8'h91, 8'h95, 8'h96, 8'h97, 8'h9A,
		8'h9B, 8'h9C, 8'h9F, 8'h05};
	always #20 clk = ~clk;
	bank1_special_register_map dut_u (
		.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
		.brownout_reset(ev[0]), .external_reset_pin(ev[1]), .watchdog_reset(ev[2]),
		.sleep_cmd(ev[3]), .wdt_clear_cmd(ev[4]),
		.psp_in_full(psp_full[1]), .psp_out_full(psp_full[0]), .psp_overflow(psp_ovf),
		.tx_shift_empty(tx_empty), .ssp_status(ssp_status),
		.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.mem_rdata(8'h5A), .pc_load(pc_load), .pc_value(pc_value), .ctl(ctl)
	);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_strobe <= 1'b1;
		@(posedge clk);
		wr_strobe <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_strobe <= 1'b1;
		@(posedge clk);
		rd_strobe <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic pulse(input int b);
		@(posedge clk);
		ev[b] <= 1'b1;
		@(posedge clk);
		ev <= 5'h00;
	endtask
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial begin
		#(40 * 4000);
		n_mismatch++;
		report_and_stop;
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		logic [7:0] d;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 14; i++) begin
			rd(RA[i], d);
			chk(d, RV[i]);
		end
		$display("test reset values done");
		for (int i = 0; i < 11; i++) begin
			wr(UA[i], 8'hFF);
			rd(UA[i], d);
			chk(d, 8'h00);
		end
		$display("test unmapped done");
		wr(8'h85, 8'hFF);
		rd(8'h85, d);
		chk(d, 8'h3F);
		wr(8'h8D, 8'hFF);
		rd(8'h8D, d);
		chk(d, 8'h01);
		wr(8'h98, 8'hFF);
		rd(8'h98, d);
		chk(d, 8'hF7);
		psp_full <= 2'h2;
		wr(8'h89, 8'hFF);
		rd(8'h89, d);
		chk(d, 8'hB7);
		// Overflow set must beat a same-cycle clear by software
		psp_ovf <= 1'b1;
		wr(8'h89, 8'h07);
		psp_ovf <= 1'b0;
		rd(8'h89, d);
		chk(d, 8'hA7);
		ssp_status <= 8'hFF;
		rd(8'h94, d);
		chk(d, 8'h3F);
		wr(8'h8C, 8'hBF);
		rd(8'h8C, d);
		chk(d, 8'hBF);
		$display("test reserved bits done");
		// Pointer zero reaches no memory
		wr(8'h04, 8'h00);
		rd(8'h80, d);
		chk(d, 8'h00);
		wr(8'h84, 8'h20);
		@(posedge clk);
		addr <= 8'h00;
		rd_strobe <= 1'b1;
		#1;
		chk({6'h00, mem_rd, mem_addr}, 16'h0220);
		@(posedge clk);
		rd_strobe <= 1'b0;
		#1;
		chk(rdata, 8'h5A);
		@(posedge clk);
		addr <= 8'h80;
		wdata <= 8'hC3;
		wr_strobe <= 1'b1;
		#1;
		chk({7'h00, mem_wr, mem_wdata}, 16'h01C3);
		@(posedge clk);
		wr_strobe <= 1'b0;
		rd(8'h04, d);
		chk(d, 8'h20);
		$display("test indirect done");
		wr(8'h0A, 8'hF2);
		rd(8'h8A, d);
		chk(d, 8'h12);
		wr(8'h82, 8'h34);
		#1;
		chk({2'h0, pc_load, pc_value}, 16'h3234);
		rd(8'h02, d);
		chk(d, 8'h34);
		wr(8'h0B, 8'hA4);
		rd(8'h8B, d);
		chk(d[7:1], 7'h52);
		$display("test program counter done");
		wr(8'h03, 8'h07);
		rd(8'h83, d);
		chk(d, 8'h1F);
		pulse(3);
		rd(8'h83, d);
		chk(d, 8'h17);
		pulse(4);
		rd(8'h03, d);
		chk(d, 8'h1F);
		$display("test flags done");
		wr(8'h86, 8'h00);
		wr(8'h8E, 8'h03);
		pulse(1);
		#1;
		chk({ctl.dir_b, ctl.ind_pointer}, 16'hFF20);
		rd(8'h86, d);
		chk(d, 8'hFF);
		rd(8'h84, d);
		chk(d, 8'h20);
		rd(8'h8E, d);
		chk(d, 8'h03);
		rd(8'h83, d);
		chk(d, 8'h1F);
		pulse(2);
		rd(8'h83, d);
		chk(d, 8'h0F);
		rd(8'h8E, d);
		chk(d, 8'h03);
		wr(8'h93, 8'h5C);
		pulse(0);
		rd(8'h8E, d);
		chk(d, 8'h02);
		rd(8'h93, d);
		chk(d, 8'h00);
		rd(8'h83, d);
		chk(d, 8'h1F);
		$display("test resets done");
		report_and_stop;
	end
endmodule
